/* src/acc_top.sv */
// calibration control register bank with apb slave and sequencer
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module acc_top
  import acc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cal_reset,
  output logic             fg_active,
  output logic             bg_active,
  output logic             fg_offset_on,
  output logic             bg_offset_on,
  output logic             serial_link_on,
  output logic             dig_tick,
  output logic             link_tick
);
  typedef struct packed {
    logic [7:0]  run;
    logic [7:0]  mode;
    logic [7:0]  extra;
    logic [7:0]  link;
    logic [3:0]  latched;
    acc_state_t  st;
    logic [7:0]  cnt;
    logic        done;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        cal_rst;
    logic        fg;
    logic        bg;
    logic        fgos;
    logic        bgos;
  } acc_state_s_t;

  acc_state_s_t s_q;
  acc_state_s_t s_d;
  logic         div_clear;
  logic         dig_w;
  logic         link_w;

  function automatic logic is_mapped(input logic [11:0] idx);
    return idx == ACC_RUN_IDX || idx == ACC_MODE_IDX ||
           idx == ACC_EXTRA_IDX || idx == ACC_STATUS_IDX ||
           idx == ACC_LINK_IDX;
  endfunction

  always_comb
  begin
    logic        acc;
    logic [11:0] idx;
    logic        wr;
    logic        run_rise;
    acc      = psel && penable && !s_q.ready;
    idx      = acc_index(paddr);
    wr       = acc && pwrite && pstrb[0] && is_mapped(idx);
    run_rise = 1'b0;
    s_d      = s_q;
    s_d.ready = acc;
    s_d.err   = acc && !is_mapped(idx);
    s_d.rdata = s_q.rdata;
    if (acc && !pwrite)
    begin
      unique case (idx)
        ACC_RUN_IDX:    s_d.rdata = {24'h00_0000, s_q.run};
        ACC_MODE_IDX:   s_d.rdata = {24'h00_0000, s_q.mode};
        ACC_EXTRA_IDX:  s_d.rdata = {24'h00_0000, s_q.extra};
        ACC_STATUS_IDX: s_d.rdata = {24'h00_0000, 1'b0, s_q.st,
                                     s_q.done, 3'b000};
        ACC_LINK_IDX:   s_d.rdata = {24'h00_0000, s_q.link};
        default:        s_d.rdata = 32'h0000_0000;
      endcase
    end
    // reserved bits are stored as written, software keeps defaults
    if (wr && idx == ACC_RUN_IDX)
      s_d.run = pwdata[7:0];
    if (wr && idx == ACC_MODE_IDX)
      s_d.mode = pwdata[7:0];
    if (wr && idx == ACC_EXTRA_IDX)
      s_d.extra = pwdata[7:0];
    if (wr && idx == ACC_LINK_IDX)
      s_d.link = pwdata[7:0];
    run_rise = s_d.run[0] && !s_q.run[0];
    s_d.cnt  = (s_q.cnt != 8'h00) ? s_q.cnt - 8'h01 : 8'h00;
    if (!s_q.run[0])
    begin
      // engine held in reset while run is low
      s_d.st      = ACC_ST_HOLD;
      s_d.done    = 1'b0;
      s_d.cal_rst = 1'b1;
    end
    else
    begin
      unique case (s_q.st)
        ACC_ST_HOLD:
        begin
          s_d.latched = s_q.mode[3:0];
          s_d.cnt     = ACC_RESET_CYC;
          s_d.st      = ACC_ST_CLEAR;
          s_d.cal_rst = 1'b1;
        end
        ACC_ST_CLEAR:
        begin
          // values always cleared before any run
          if (s_q.cnt <= 8'h01)
          begin
            s_d.cal_rst = 1'b0;
            if (s_q.latched[ACC_FG_BIT])
            begin
              s_d.st  = ACC_ST_FORE;
              s_d.cnt = ACC_FG_CYC;
            end
            else
              s_d.st = ACC_ST_BACK;
          end
        end
        ACC_ST_FORE:
          if (s_q.cnt <= 8'h01)
            s_d.st = ACC_ST_BACK;
        ACC_ST_BACK:
        begin
          s_d.done = 1'b1;
          s_d.st   = ACC_ST_IDLE;
        end
        ACC_ST_IDLE:
          s_d.st = ACC_ST_IDLE;
      endcase
    end
    s_d.fg   = s_d.st == ACC_ST_FORE;
    s_d.bg   = s_d.latched[ACC_BG_BIT] && s_d.st == ACC_ST_IDLE;
    // offset only valid alongside its parent mode
    s_d.fgos = s_d.fg && s_d.latched[ACC_FGOS_BIT];
    s_d.bgos = s_d.bg && s_d.latched[ACC_BGOS_BIT];
    if (run_rise)
      s_d.st = ACC_ST_HOLD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q         <= '0;
      s_q.run     <= ACC_RUN_RST;
      s_q.mode    <= ACC_MODE_RST;
      s_q.extra   <= ACC_EXTRA_RST;
      s_q.latched <= 4'h0;
      s_q.st      <= ACC_ST_HOLD;
      s_q.cal_rst <= 1'b1;
    end
    else if (ce)
      s_q <= s_d;
  end

  assign div_clear = !s_q.run[0];

  acc_divider u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .div_clear (div_clear),
    .dig_tick  (dig_w),
    .link_tick (link_w)
  );

  assign prdata         = s_q.rdata;
  assign pready         = s_q.ready;
  assign pslverr        = s_q.err;
  assign cal_reset      = s_q.cal_rst;
  assign fg_active      = s_q.fg;
  assign bg_active      = s_q.bg;
  assign fg_offset_on   = s_q.fgos;
  assign bg_offset_on   = s_q.bgos;
  assign serial_link_on = s_q.link[0];
  assign dig_tick       = dig_w;
  assign link_tick      = link_w;
endmodule
`default_nettype wire

/* pkg/acc_pkg.sv */
// package: register map, reset values and field positions for calibration control
package acc_pkg;
  localparam logic [11:0] ACC_RUN_IDX     = 12'h061;
  localparam logic [11:0] ACC_MODE_IDX    = 12'h062;
  localparam logic [11:0] ACC_EXTRA_IDX   = 12'h065;
  localparam logic [11:0] ACC_STATUS_IDX  = 12'h066;
  localparam logic [11:0] ACC_LINK_IDX    = 12'h067;
  localparam logic [7:0]  ACC_RUN_RST     = 8'h01;
  localparam logic [7:0]  ACC_MODE_RST    = 8'h01;
  localparam logic [7:0]  ACC_EXTRA_RST   = 8'h01;
  localparam int          ACC_FG_BIT      = 0;
  localparam int          ACC_BG_BIT      = 1;
  localparam int          ACC_FGOS_BIT    = 2;
  localparam int          ACC_BGOS_BIT    = 3;
  localparam int          ACC_RESET_NS    = 100;
  localparam int          ACC_CLK_MHZ     = 100;
  localparam logic [7:0]  ACC_RESET_CYC   =
    8'((ACC_RESET_NS * ACC_CLK_MHZ + 999) / 1000);
  localparam int          ACC_FG_NS       = 1000;
  localparam logic [7:0]  ACC_FG_CYC      =
    8'((ACC_FG_NS * ACC_CLK_MHZ) / 1000);
  typedef enum logic [2:0] {
    ACC_ST_HOLD,
    ACC_ST_CLEAR,
    ACC_ST_FORE,
    ACC_ST_BACK,
    ACC_ST_IDLE
  } acc_state_t;
  function automatic logic [11:0] acc_index(input logic [13:0] a);
    return a[13:2];
  endfunction
endpackage

/* src/acc_divider.sv */
// divider producing digital-block and link clock enables, held by reset
`timescale 1ns/1ps
`default_nettype none
module acc_divider
  import acc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic div_clear,
  output logic      dig_tick,
  output logic      link_tick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       dig;
    logic       link;
  } acc_div_t;
  acc_div_t s_q;
  acc_div_t s_d;
  always_comb
  begin
    s_d      = s_q;
    s_d.dig  = 1'b0;
    s_d.link = 1'b0;
    if (div_clear)
    begin
      s_d.cnt = 4'h0;
    end
    else
    begin
      s_d.cnt  = s_q.cnt + 4'h1;
      s_d.dig  = s_q.cnt[0];
      s_d.link = (s_q.cnt == 4'hf);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end
  assign dig_tick  = s_q.dig;
  assign link_tick = s_q.link;
endmodule
`default_nettype wire

/* dv/acc_checker.sv */
// checker: bus timing and sequencer properties for calibration control
`timescale 1ns/1ps
`default_nettype none
module acc_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cal_reset,
  input wire logic fg_active,
  input wire logic dig_tick,
  input wire logic link_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fg_rise;
    !fg_active ##1 fg_active;
  endsequence
  // a pass cut short by clearing run drops fg with cal_reset high
  sequence s_fg_fall;
    fg_active ##1 (!fg_active && !cal_reset);
  endsequence
  property p_hold; cal_reset |-> !fg_active; endproperty
  property p_rise; s_fg_rise |-> $past(cal_reset, 2); endproperty
  // a foreground pass runs 100 cycles; 8 is the cheap lower bound
  property p_fore; s_fg_fall |-> $past(fg_active, 8); endproperty
  property p_ans; psel && penable && !pready && ce |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_dig; dig_tick |=> !dig_tick; endproperty
  property p_link; link_tick |=> !link_tick [*8]; endproperty
  a_hold: assert property (p_hold) else $error("active in reset");
  a_rise: assert property (p_rise) else $error("no clear first");
  a_fore: assert property (p_fore) else $error("short pass");
  a_ans: assert property (p_ans) else $error("no answer");
  a_pulse: assert property (p_pulse) else $error("long ready");
  a_err: assert property (p_err) else $error("lone error");
  a_dig: assert property (p_dig) else $error("dig tick rate");
  a_link: assert property (p_link) else $error("link rate");
endmodule
bind acc_top acc_checker i_chk (
  .pclk      (pclk),
  .presetn   (presetn),
  .ce        (ce),
  .psel      (psel),
  .penable   (penable),
  .pready    (pready),
  .pslverr   (pslverr),
  .cal_reset (cal_reset),
  .fg_active (fg_active),
  .dig_tick  (dig_tick),
  .link_tick (link_tick)
);
`default_nettype wire

/* dv/acc_top_tb.sv */
// self-checking bench for the calibration control block
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb;
  import acc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, cal_reset, fg_active, bg_active, er, s;
  logic fg_offset_on, bg_offset_on, serial_link_on, dig_tick, link_tick;
  int miscompares = 0, n_compared = 0;
  always #5 pclk = ~pclk;
  acc_top i_acc_top (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cal_reset(cal_reset), .fg_active(fg_active),
    .bg_active(bg_active), .fg_offset_on(fg_offset_on),
    .bg_offset_on(bg_offset_on), .serial_link_on(serial_link_on),
    .dig_tick(dig_tick), .link_tick(link_tick));
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] v, input logic [31:0] x);
    n_compared++;
    if (v !== x)
    begin
      miscompares++;
      $display("[ERR] %0t saw %h want %h", $time, v, x);
    end
  endtask
  task hang;
    miscompares++;
    close_out;
  endtask
  task apb(input logic w, input logic [11:0] i, input logic [7:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20) hang;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wait_fg(input logic v);
    int n;
    n = 0;
    while (fg_active !== v && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 400) hang;
  endtask
  task t_defaults;
    apb(0, ACC_RUN_IDX, 0);
    chk(rd, 32'h0000_0001);
    apb(0, ACC_MODE_IDX, 0);
    chk(rd, 32'h0000_0001);
    apb(0, ACC_EXTRA_IDX, 0);
    chk(rd, 32'h0000_0001);
    apb(0, 12'h070, 0);
    chk(er, 1);
    wait_fg(1);
    wait_fg(0);
    apb(0, ACC_STATUS_IDX, 0);
    chk(rd[3], 1'b1);
    $display("defaults done");
  endtask
  task t_modes;
    apb(1, ACC_RUN_IDX, 0);
    chk(cal_reset, 1);
    repeat (2) @(posedge pclk);
    s = 0;
    repeat (20)
    begin
      @(posedge pclk);
      s = s | dig_tick | link_tick;
    end
    chk(s, 0);
    apb(1, ACC_MODE_IDX, 8'h0f);
    apb(0, ACC_MODE_IDX, 0);
    chk(rd, 32'h0000_000f);
    apb(1, ACC_RUN_IDX, 1);
    wait_fg(1);
    chk(fg_offset_on, 1);
    wait_fg(0);
    repeat (2) @(posedge pclk);
    chk(bg_active, 1);
    chk(bg_offset_on, 1);
    $display("modes done");
  endtask
  task t_skip;
    int nd;
    int nl;
    nd = 0;
    nl = 0;
    apb(1, ACC_RUN_IDX, 0);
    apb(1, ACC_MODE_IDX, 0);
    apb(1, ACC_RUN_IDX, 1);
    s = 0;
    // nine full link periods with the dividers running free
    repeat (144)
    begin
      @(posedge pclk);
      s = s | fg_active;
      if (dig_tick === 1'b1)
        nd++;
      if (link_tick === 1'b1)
        nl++;
    end
    chk(s, 0);
    chk(bg_active, 0);
    chk(nd, 72);
    chk(nl, 9);
    $display("skip done");
  endtask
  task t_link;
    apb(1, ACC_LINK_IDX, 1);
    chk(serial_link_on, 1);
    apb(1, ACC_LINK_IDX, 0);
    apb(1, ACC_RUN_IDX, 0);
    chk(serial_link_on, 0);
    chk(cal_reset, 1);
    $display("link done");
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_defaults;
    t_modes;
    t_skip;
    t_link;
    close_out;
  end
endmodule
`default_nettype wire
